// *** dsp_addr_pkg.sv ***
package dsp_addr_pkg;
  // ******************************************************
  // widths
  // ******************************************************
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int NUM_AUX = 8;
  localparam int NUM_EXT = 8;
  localparam logic [4:0] NUM_CPU_REGS = 5'h1c;
  // ******************************************************
  // request modes
  // ******************************************************
  localparam logic [2:0] MODE_REG = 3'h0;
  localparam logic [2:0] MODE_SIMM = 3'h1;
  localparam logic [2:0] MODE_DIRECT = 3'h2;
  localparam logic [2:0] MODE_INDIR = 3'h3;
  localparam logic [2:0] MODE_LIMM = 3'h4;
  localparam logic [2:0] MODE_BR_REG = 3'h5;
  localparam logic [2:0] MODE_BR_REL = 3'h6;
  localparam logic [2:0] MODE_COND = 3'h7;
  // operand groups
  localparam logic [1:0] GRP_GEN = 2'h0;
  localparam logic [1:0] GRP_THREE = 2'h1;
  localparam logic [1:0] GRP_PAR = 2'h2;
  // short immediate interpretation
  localparam logic [1:0] IMM_SIGNED = 2'h0;
  localparam logic [1:0] IMM_UNSIGNED = 2'h1;
  localparam logic [1:0] IMM_FLOAT = 2'h2;
  // ******************************************************
  // instruction word fields
  // ******************************************************
  localparam int F_DISP_LO = 0;
  localparam int F_DISP_HI = 7;
  localparam int F_AR_LO = 8;
  localparam int F_AR_HI = 10;
  localparam int F_IMOD_LO = 11;
  localparam int F_IMOD_HI = 14;
  localparam int F_IMM_HI = 15;
  localparam int F_LIMM_HI = 23;
  localparam int F_DSEL_LO = 16;
  localparam int F_DSEL_HI = 17;
  localparam int F_SLOT_LO = 18;
  localparam int F_SLOT_HI = 19;
  localparam int F_REG_HI = 4;
  localparam int F_COND_LO = 24;
  localparam int F_COND_HI = 28;
  // displacement source
  localparam logic [1:0] DSEL_CONST = 2'h0;
  localparam logic [1:0] DSEL_OFF0 = 2'h1;
  localparam logic [1:0] DSEL_OFF1 = 2'h2;
  // parallel register slot class
  localparam logic [1:0] SLOT_ANY = 2'h0;
  localparam logic [1:0] SLOT_PAIR01 = 2'h1;
  localparam logic [1:0] SLOT_PAIR23 = 2'h2;
  // indirect forms
  localparam logic [3:0] IM_PLAIN = 4'h0;
  localparam logic [3:0] IM_PRE_ADD = 4'h1;
  localparam logic [3:0] IM_PRE_SUB = 4'h2;
  localparam logic [3:0] IM_PRE_ADD_MOD = 4'h3;
  localparam logic [3:0] IM_PRE_SUB_MOD = 4'h4;
  localparam logic [3:0] IM_POST_ADD = 4'h5;
  localparam logic [3:0] IM_POST_SUB = 4'h6;
  localparam logic [3:0] IM_POST_ADD_CIRC = 4'h7;
  localparam logic [3:0] IM_POST_SUB_CIRC = 4'h8;
  localparam logic [3:0] IM_POST_BITREV = 4'h9;
  // ******************************************************
  // status flag bit positions
  // ******************************************************
  localparam int FL_C = 0;
  localparam int FL_V = 1;
  localparam int FL_Z = 2;
  localparam int FL_N = 3;
  localparam int FL_UF = 4;
  localparam int FL_LV = 5;
  localparam int FL_LUF = 6;
  localparam int FLAGS_W = 7;
  // ******************************************************
  // condition codes
  // ******************************************************
  localparam logic [4:0] CC_U = 5'h00;
  localparam logic [4:0] CC_LO = 5'h01;
  localparam logic [4:0] CC_LS = 5'h02;
  localparam logic [4:0] CC_HI = 5'h03;
  localparam logic [4:0] CC_HS = 5'h04;
  localparam logic [4:0] CC_EQ = 5'h05;
  localparam logic [4:0] CC_NE = 5'h06;
  localparam logic [4:0] CC_LT = 5'h07;
  localparam logic [4:0] CC_LE = 5'h08;
  localparam logic [4:0] CC_GT = 5'h09;
  localparam logic [4:0] CC_GE = 5'h0a;
  localparam logic [4:0] CC_NN = 5'h0b;
  localparam logic [4:0] CC_NV = 5'h0c;
  localparam logic [4:0] CC_V = 5'h0d;
  localparam logic [4:0] CC_NUF = 5'h0e;
  localparam logic [4:0] CC_UF = 5'h0f;
  localparam logic [4:0] CC_NLV = 5'h10;
  localparam logic [4:0] CC_LV = 5'h11;
  localparam logic [4:0] CC_NO_STICKY_FP_UNDERFLOW_COND = 5'h12;
  localparam logic [4:0] CC_LUF = 5'h13;
  localparam logic [4:0] CC_ZUF = 5'h14;
  // ******************************************************
  // register offsets and reset values
  // ******************************************************
  localparam logic [4:0] OFF_PAGE = 5'h00;
  localparam logic [4:0] OFF_OFFS0 = 5'h01;
  localparam logic [4:0] OFF_OFFS1 = 5'h02;
  localparam logic [4:0] OFF_CSTART = 5'h03;
  localparam logic [4:0] OFF_CSIZE = 5'h04;
  localparam logic [4:0] OFF_FLAGS = 5'h05;
  localparam logic [4:0] OFF_PC = 5'h06;
  localparam logic [4:0] OFF_LAST = 5'h07;
  localparam logic [4:0] OFF_AUX0 = 5'h08;
  localparam logic [ADDR_W-1:0] RST_ADDR = 24'h000000;
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [FLAGS_W-1:0] RST_FLAGS = 7'h00;
endpackage

// *** cond_eval.sv ***
`timescale 1ns/10ps
module cond_eval (
  input wire logic [4:0] cond,
  input wire logic [dsp_addr_pkg::FLAGS_W-1:0] flags,
  output logic truth,
  output logic known
);
  import dsp_addr_pkg::*;
  // ******************************************************
  // condition decode
  // ******************************************************
  logic c, v, z, n, uf, lv, sticky_fp_underflow_flag; // flag aliases
  assign c = flags[FL_C];
  assign v = flags[FL_V];
  assign z = flags[FL_Z];
  assign n = flags[FL_N];
  assign uf = flags[FL_UF];
  assign lv = flags[FL_LV];
  assign sticky_fp_underflow_flag = flags[FL_LUF];

  // combinational truth of the 5-bit field
  always_comb begin
    known = 1'b1;
    unique case (cond)
      CC_U: truth = 1'b1;
      CC_LO: truth = c;
      CC_LS: truth = c | z;
      CC_HI: truth = ~c & ~z;
      CC_HS: truth = ~c;
      CC_EQ: truth = z;
      CC_NE: truth = ~z;
      CC_LT: truth = n;
      CC_LE: truth = n | z;
      CC_GT: truth = ~n & ~z;
      CC_GE: truth = ~n;
      CC_NN: truth = ~n;
      CC_NV: truth = ~v;
      CC_V: truth = v;
      CC_NUF: truth = ~uf;
      CC_UF: truth = uf;
      CC_NLV: truth = ~lv;
      CC_LV: truth = lv;
      CC_NO_STICKY_FP_UNDERFLOW_COND: truth = ~sticky_fp_underflow_flag;
      CC_LUF: truth = sticky_fp_underflow_flag;
      CC_ZUF: truth = z | uf;
      default: begin
        // undefined codes never pass
        truth = 1'b0;
        known = 1'b0;
      end
    endcase
  end
endmodule

// *** operand_addr_unit.sv ***
`timescale 1ns/10ps
module operand_addr_unit (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] reg_addr,
  input wire logic [dsp_addr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dsp_addr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic req_valid,
  input wire logic [2:0] req_mode,
  input wire logic [1:0] req_group,
  input wire logic req_fp,
  input wire logic [1:0] req_imm_kind,
  input wire logic [dsp_addr_pkg::DATA_W-1:0] req_instr,
  input wire logic [dsp_addr_pkg::DATA_W-1:0] req_reg_val,
  output logic ans_valid,
  output logic ans_illegal,
  output logic [dsp_addr_pkg::ADDR_W-1:0] ans_addr,
  output logic [dsp_addr_pkg::DATA_W-1:0] ans_imm,
  output logic [4:0] ans_reg,
  output logic ans_cond_true,
  output logic ans_taken,
  output logic [dsp_addr_pkg::ADDR_W-1:0] pc
);
  import dsp_addr_pkg::*;

  // ******************************************************
  // helper functions
  // ******************************************************
  // mirror a 24-bit word end for end
  function automatic logic [ADDR_W-1:0] rev24(input logic [ADDR_W-1:0] x);
    logic [ADDR_W-1:0] r;
    r = '0;
    for (int i = 0; i < ADDR_W; i++) begin
      r[i] = x[ADDR_W-1-i];
    end
    return r;
  endfunction

  // ******************************************************
  // state
  // ******************************************************
  logic [7:0] page_pointer_reg_r; // upper direct address bits
  logic [ADDR_W-1:0] first_offset_reg_r; // index register 0
  logic [ADDR_W-1:0] second_offset_reg_r; // index register 1
  logic [ADDR_W-1:0] circ_start_r; // circular buffer base
  logic [ADDR_W-1:0] circ_size_r; // circular buffer length
  logic [FLAGS_W-1:0] flags_r; // status flags
  logic [ADDR_W-1:0] aux_pointer_reg_r [NUM_AUX]; // pointers
  logic [ADDR_W-1:0] pc_r; // program counter
  logic [ADDR_W-1:0] last_addr_r; // last operand address
  logic [DATA_W-1:0] rdata_r; // read data register
  logic ans_valid_r, ans_illegal_r, ans_cond_true_r, ans_taken_r;
  logic [ADDR_W-1:0] ans_addr_r;
  logic [DATA_W-1:0] ans_imm_r;
  logic [4:0] ans_reg_r;

  // ******************************************************
  // decode of the request
  // ******************************************************
  logic [2:0] ar_idx; // selected pointer
  logic [3:0] imod; // indirect form
  logic [1:0] dsel; // displacement source
  logic [1:0] slot; // parallel slot class
  logic [4:0] rnum; // register number
  logic [4:0] cond; // condition field
  logic [ADDR_W-1:0] ar_cur; // pointer before update
  logic [ADDR_W-1:0] disp; // chosen displacement
  logic [ADDR_W-1:0] sum_v, dif_v, circ_end; // adder outputs
  logic cond_truth, cond_known; // condition result

  assign ar_idx = req_instr[F_AR_HI:F_AR_LO];
  assign imod = req_instr[F_IMOD_HI:F_IMOD_LO];
  assign dsel = req_instr[F_DSEL_HI:F_DSEL_LO];
  assign slot = req_instr[F_SLOT_HI:F_SLOT_LO];
  assign rnum = req_instr[F_REG_HI:0];
  assign cond = req_instr[F_COND_HI:F_COND_LO];
  assign ar_cur = aux_pointer_reg_r[ar_idx];
  assign sum_v = ar_cur + disp;
  assign dif_v = ar_cur - disp;
  assign circ_end = circ_start_r + circ_size_r;

  // condition evaluator on the current flags
  cond_eval u_cond (
    .cond(cond),
    .flags(flags_r),
    .truth(cond_truth),
    .known(cond_known)
  );

  // displacement selection
  always_comb begin
    unique case (dsel)
      DSEL_OFF0: disp = first_offset_reg_r;
      DSEL_OFF1: disp = second_offset_reg_r;
      default: disp = {16'h0000, req_instr[F_DISP_HI:F_DISP_LO]};
    endcase
  end

  logic [ADDR_W-1:0] ea_nxt, ar_nxt, pc_nxt; // computed values
  logic ar_we, bad, taken; // update, illegal, branch
  logic [DATA_W-1:0] imm_nxt; // immediate result

  // operand address and pointer update
  always_comb begin
    ea_nxt = RST_ADDR;
    ar_nxt = ar_cur;
    ar_we = 1'b0;
    bad = 1'b0;
    imm_nxt = '0;
    taken = 1'b0;
    pc_nxt = pc_r;
    unique case (req_mode)
      MODE_REG: begin
        // float ops use only extended registers
        if ((req_fp || req_group == GRP_PAR) && rnum >= 5'(NUM_EXT)) begin
          bad = 1'b1;
        end
        if (rnum >= NUM_CPU_REGS) begin
          bad = 1'b1;
        end
        if (req_group == GRP_PAR && slot == SLOT_PAIR01 &&
            rnum[4:1] != 4'h0) begin
          bad = 1'b1;
        end
        if (req_group == GRP_PAR && slot == SLOT_PAIR23 &&
            rnum[4:1] != 4'h1) begin
          bad = 1'b1;
        end
      end
      MODE_SIMM: begin
        if (req_imm_kind == IMM_SIGNED) begin
          imm_nxt = {{16{req_instr[F_IMM_HI]}}, req_instr[F_IMM_HI:0]};
        end else begin
          imm_nxt = {16'h0000, req_instr[F_IMM_HI:0]};
        end
        if (req_group != GRP_GEN) begin
          bad = 1'b1;
        end
      end
      MODE_DIRECT: begin
        ea_nxt = {page_pointer_reg_r, req_instr[F_IMM_HI:0]};
        if (req_group != GRP_GEN) begin
          bad = 1'b1;
        end
      end
      MODE_LIMM: begin
        ea_nxt = req_instr[F_LIMM_HI:0];
        imm_nxt = {8'h00, req_instr[F_LIMM_HI:0]};
      end
      MODE_INDIR: begin
        if (dsel == 2'h3) begin
          bad = 1'b1;
        end
        // reduced displacement set
        if (req_group != GRP_GEN && dsel == DSEL_CONST &&
            disp > 24'h000001) begin
          bad = 1'b1;
        end
        unique case (imod)
          IM_PLAIN: ea_nxt = ar_cur;
          IM_PRE_ADD: ea_nxt = sum_v;
          IM_PRE_SUB: ea_nxt = dif_v;
          IM_PRE_ADD_MOD: begin
            ea_nxt = sum_v;
            ar_nxt = sum_v;
            ar_we = 1'b1;
          end
          IM_PRE_SUB_MOD: begin
            ea_nxt = dif_v;
            ar_nxt = dif_v;
            ar_we = 1'b1;
          end
          IM_POST_ADD, IM_POST_SUB: begin
            ea_nxt = ar_cur;
            ar_nxt = (imod == IM_POST_ADD) ? sum_v : dif_v;
            ar_we = 1'b1;
          end
          IM_POST_ADD_CIRC: begin
            ea_nxt = ar_cur;
            // wrap back into the buffer at its end
            ar_nxt = (sum_v >= circ_end) ? sum_v - circ_size_r : sum_v;
            ar_we = 1'b1;
          end
          IM_POST_SUB_CIRC: begin
            ea_nxt = ar_cur;
            // wrap forward past the buffer base
            ar_nxt = (dif_v < circ_start_r) ? dif_v + circ_size_r : dif_v;
            ar_we = 1'b1;
          end
          IM_POST_BITREV: begin
            ea_nxt = ar_cur;
            // carry runs from high bit to low bit
            ar_nxt = rev24(rev24(ar_cur) + rev24(first_offset_reg_r));
            ar_we = 1'b1;
          end
          default: bad = 1'b1;
        endcase
      end
      MODE_BR_REG: begin
        taken = cond_truth;
        pc_nxt = cond_truth ? req_reg_val[ADDR_W-1:0] : pc_r;
      end
      MODE_BR_REL: begin
        taken = cond_truth;
        pc_nxt = cond_truth ?
          pc_r + {{8{req_instr[F_IMM_HI]}}, req_instr[F_IMM_HI:0]} :
          pc_r;
      end
      MODE_COND: begin
        taken = cond_truth;
      end
      default: bad = 1'b1;
    endcase
    if ((req_mode == MODE_BR_REG || req_mode == MODE_BR_REL ||
         req_mode == MODE_COND) && !cond_known) begin
      bad = 1'b1;
      taken = 1'b0;
      pc_nxt = pc_r;
    end
    if (bad) begin
      ar_we = 1'b0;
    end
  end

  // ******************************************************
  // software-visible registers
  // ******************************************************
  // configuration registers, software writes only
  always_ff @(posedge clk) begin
    if (!resetn) begin
      page_pointer_reg_r <= RST_PAGE;
      first_offset_reg_r <= RST_ADDR;
      second_offset_reg_r <= RST_ADDR;
      circ_start_r <= RST_ADDR;
      circ_size_r <= RST_ADDR;
      flags_r <= RST_FLAGS;
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFF_PAGE: page_pointer_reg_r <= reg_wdata[7:0];
        OFF_OFFS0: first_offset_reg_r <= reg_wdata[ADDR_W-1:0];
        OFF_OFFS1: second_offset_reg_r <= reg_wdata[ADDR_W-1:0];
        OFF_CSTART: circ_start_r <= reg_wdata[ADDR_W-1:0];
        OFF_CSIZE: circ_size_r <= reg_wdata[ADDR_W-1:0];
        OFF_FLAGS: flags_r <= reg_wdata[FLAGS_W-1:0];
        default: ;
      endcase
    end
  end

  // pointer file: a software write beats a decoder update
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_AUX; i++) begin
        aux_pointer_reg_r[i] <= RST_ADDR;
      end
    end else if (reg_wr && reg_addr[4:3] == OFF_AUX0[4:3]) begin
      aux_pointer_reg_r[reg_addr[2:0]] <= reg_wdata[ADDR_W-1:0];
    end else if (req_valid && ar_we) begin
      aux_pointer_reg_r[ar_idx] <= ar_nxt;
    end
  end

  // program counter, software write beats a branch
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pc_r <= RST_ADDR;
    end else if (reg_wr && reg_addr == OFF_PC) begin
      pc_r <= reg_wdata[ADDR_W-1:0];
    end else if (req_valid) begin
      pc_r <= pc_nxt;
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      if (reg_addr[4:3] == OFF_AUX0[4:3]) begin
        rdata_r <= {8'h00, aux_pointer_reg_r[reg_addr[2:0]]};
      end else begin
        unique case (reg_addr)
          OFF_PAGE: rdata_r <= {24'h000000, page_pointer_reg_r};
          OFF_OFFS0: rdata_r <= {8'h00, first_offset_reg_r};
          OFF_OFFS1: rdata_r <= {8'h00, second_offset_reg_r};
          OFF_CSTART: rdata_r <= {8'h00, circ_start_r};
          OFF_CSIZE: rdata_r <= {8'h00, circ_size_r};
          OFF_FLAGS: rdata_r <= {25'h0000000, flags_r};
          OFF_PC: rdata_r <= {8'h00, pc_r};
          OFF_LAST: rdata_r <= {8'h00, last_addr_r};
          default: rdata_r <= '0;
        endcase
      end
    end else begin
      rdata_r <= '0;
    end
  end

  // ******************************************************
  // answer registers
  // ******************************************************
  // answer of each request, one cycle later
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ans_valid_r <= 1'b0;
      ans_illegal_r <= 1'b0;
      ans_addr_r <= RST_ADDR;
      ans_imm_r <= '0;
      ans_reg_r <= 5'h00;
      ans_cond_true_r <= 1'b0;
      ans_taken_r <= 1'b0;
    end else begin
      ans_valid_r <= req_valid;
      ans_illegal_r <= req_valid & bad;
      ans_addr_r <= req_valid ? ea_nxt : RST_ADDR;
      ans_imm_r <= req_valid ? imm_nxt : '0;
      ans_reg_r <= req_valid ? rnum : 5'h00;
      ans_cond_true_r <= req_valid & cond_truth & cond_known;
      ans_taken_r <= req_valid & taken;
    end
  end

  // last operand address, kept for software
  always_ff @(posedge clk) begin
    if (!resetn) begin
      last_addr_r <= RST_ADDR;
    end else if (req_valid && !bad) begin
      last_addr_r <= ea_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign ans_valid = ans_valid_r;
  assign ans_illegal = ans_illegal_r;
  assign ans_addr = ans_addr_r;
  assign ans_imm = ans_imm_r;
  assign ans_reg = ans_reg_r;
  assign ans_cond_true = ans_cond_true_r;
  assign ans_taken = ans_taken_r;
  assign pc = pc_r;

  // ******************************************************
  // checks
  // ******************************************************
  logic no_wr; // no software write in flight
  assign no_wr = !reg_wr;

  direct_addr_a: assert property (@(posedge clk) disable iff (!resetn)
    req_valid && req_mode == MODE_DIRECT |=>
      ans_addr == {$past(page_pointer_reg_r), $past(req_instr[15:0])})
    else $error("direct address not page plus field");

  simm_sext_a: assert property (@(posedge clk) disable iff (!resetn)
    req_valid && req_mode == MODE_SIMM && req_imm_kind == IMM_SIGNED |=>
      ans_imm == {{16{$past(req_instr[15])}}, $past(req_instr[15:0])})
    else $error("short immediate not sign extended");

  plain_keep_a: assert property (@(posedge clk) disable iff (!resetn)
    req_valid && no_wr && req_mode == MODE_INDIR && imod == IM_PLAIN |=>
      ans_addr == $past(ar_cur) &&
      aux_pointer_reg_r[$past(ar_idx)] == $past(ar_cur))
    else $error("plain indirect changed pointer");

  pre_nomod_a: assert property (@(posedge clk) disable iff (!resetn)
    req_valid && no_wr && req_mode == MODE_INDIR && imod == IM_PRE_ADD &&
    !bad |=> ans_addr == $past(sum_v) &&
      aux_pointer_reg_r[$past(ar_idx)] == $past(ar_cur))
    else $error("pre-add without modify wrong");

  pre_mod_a: assert property (@(posedge clk) disable iff (!resetn)
    req_valid && no_wr && req_mode == MODE_INDIR &&
    imod == IM_PRE_SUB_MOD && !bad |=>
      aux_pointer_reg_r[$past(ar_idx)] == ans_addr)
    else $error("pre-sub modify not written back");

  post_old_a: assert property (@(posedge clk) disable iff (!resetn)
    req_valid && no_wr && req_mode == MODE_INDIR &&
    imod == IM_POST_ADD && !bad |=> ans_addr == $past(ar_cur) &&
      aux_pointer_reg_r[$past(ar_idx)] == $past(ar_cur) + $past(disp))
    else $error("post-add address or update wrong");

  limited_disp_a: assert property (@(posedge clk) disable iff (!resetn)
    req_valid && req_mode == MODE_INDIR && req_group == GRP_THREE &&
    dsel == DSEL_CONST && req_instr[7:1] != 7'h00 |=> ans_illegal)
    else $error("large displacement accepted");

  fp_reg_a: assert property (@(posedge clk) disable iff (!resetn)
    req_valid && req_mode == MODE_REG && req_fp && rnum[4:3] != 2'h0
    |=> ans_illegal && ans_reg == $past(rnum))
    else $error("float operand outside extended set");

  uncond_a: assert property (@(posedge clk) disable iff (!resetn)
    req_valid && req_mode == MODE_COND && cond == CC_U |=> ans_taken)
    else $error("unconditional code not taken");

  rel_branch_a: assert property (@(posedge clk) disable iff (!resetn)
    req_valid && no_wr && req_mode == MODE_BR_REL && cond == CC_U |=>
      pc == $past(pc) + {{8{$past(req_instr[15])}}, $past(req_instr[15:0])})
    else $error("relative branch target wrong");
endmodule

// *** instr_fetch.sv ***
`timescale 1ns/10ps
// ****************************************
// instruction stream model
// ****************************************
module instr_fetch (
  input wire logic clk,
  input wire logic [31:0] next_word,
  output logic [31:0] word
);
  // fetched word lands one cycle after it is asked for
  always_ff @(posedge clk) begin
    word <= next_word;
  end
endmodule

// *** test_operand_addr_unit.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin \
  n_compared++; \
  if ((a) !== (b)) begin \
    miscompares++; \
    $display("Error %0t: got %h want %h", $time, a, b); \
  end \
end
module test_operand_addr_unit;
  import dsp_addr_pkg::*;
  logic clk, resetn, reg_wr, reg_rd, req_valid, req_fp;
  logic [4:0] reg_addr, ans_reg;
  logic [2:0] req_mode;
  logic [1:0] req_group, req_imm_kind;
  logic [31:0] reg_wdata, req_reg_val, next_word, req_instr, reg_rdata;
  logic [31:0] ans_imm, rv, seed;
  logic ans_valid, ans_illegal, ans_cond_true, ans_taken;
  logic [23:0] ans_addr, pc, p, s, q;
  logic [6:0] f;
  logic [7:0] d;
  logic [1:0] sl, g;
  logic e;
  int miscompares, n_compared, k;
  instr_fetch instr_fetch_inst (.clk, .next_word, .word(req_instr));
  operand_addr_unit operand_addr_unit_inst (.clk, .resetn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .req_valid, .req_mode,
    .req_group, .req_fp, .req_imm_kind, .req_instr, .req_reg_val,
    .ans_valid, .ans_illegal, .ans_addr, .ans_imm, .ans_reg,
    .ans_cond_true, .ans_taken, .pc);
  // pseudo-random step
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // reference condition truth table, codes above 20 never true
  function automatic logic cmodel(logic [4:0] c, logic [6:0] g);
    logic [20:0] t;
    t = {g[FL_Z] | g[FL_UF], g[FL_LUF], !g[FL_LUF], g[FL_LV], !g[FL_LV],
      g[FL_UF], !g[FL_UF], g[FL_V], !g[FL_V], !g[FL_N], !g[FL_N],
      !(g[FL_N] | g[FL_Z]), g[FL_N] | g[FL_Z], g[FL_N], !g[FL_Z], g[FL_Z],
      !g[FL_C], !(g[FL_C] | g[FL_Z]), g[FL_C] | g[FL_Z], g[FL_C], 1'b1};
    return (c > 20) ? 1'b0 : t[c];
  endfunction
  // reference bit-reversed add, carries run toward bit zero
  function automatic logic [23:0] brev_add(logic [23:0] a, logic [23:0] b);
    logic [23:0] r;
    logic c;
    c = 1'b0;
    for (int j = 23; j >= 0; j--) begin
      r[j] = a[j] ^ b[j] ^ c;
      c = (a[j] & b[j]) | (c & (a[j] ^ b[j]));
    end
    return r;
  endfunction
  task automatic wr(logic [4:0] a, logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(logic [4:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  task automatic req(logic [2:0] m, logic [31:0] w);
    @(posedge clk);
    next_word <= w;
    @(posedge clk);
    req_valid <= 1'b1;
    req_mode <= m;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    `CHK(ans_valid, 1'b1)
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // watchdog, far beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
  initial begin
    {resetn, reg_wr, reg_rd, req_valid, req_fp, reg_addr, req_mode} = '0;
    {req_group, req_imm_kind, reg_wdata, req_reg_val, next_word} = '0;
    seed = 32'hc3699ce7;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    // every condition code against random flags
    for (int i = 0; i < 128; i++) begin
      seed = lfsr(seed);
      f = seed[6:0];
      wr(OFF_FLAGS, {25'h0, f});
      req(MODE_COND, {3'h0, i[4:0], seed[31:8]});
      `CHK(ans_cond_true, cmodel(i[4:0], f))
      `CHK(ans_taken, cmodel(i[4:0], f))
      `CHK(ans_illegal, i[4:0] > 5'h14)
    end
    // direct, long immediate and both branch kinds
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wr(OFF_PAGE, {24'h0, seed[31:24]});
      req(MODE_DIRECT, {16'h0, seed[15:0]});
      `CHK(ans_addr, {seed[31:24], seed[15:0]})
      req(MODE_LIMM, seed);
      `CHK(ans_imm, {8'h0, seed[23:0]})
      wr(OFF_PC, seed);
      req_reg_val <= ~seed;
      req(MODE_BR_REL, {16'h0, seed[31:16]});
      p = seed[23:0] + {{8{seed[31]}}, seed[31:16]};
      `CHK(pc, p)
      // register branch under a random condition
      req(MODE_BR_REG, {3'h0, seed[12:8], 24'h0});
      `CHK(ans_taken, cmodel(seed[12:8], f))
      `CHK(pc, cmodel(seed[12:8], f) ? ~seed[23:0] : p)
    end
    // indirect forms, circular buffer at 0x100 of 0x40 words
    seed = lfsr(seed);
    q = seed[23:0];
    wr(OFF_OFFS0, {8'h0, q});
    wr(OFF_CSTART, 32'h00000100);
    wr(OFF_CSIZE, 32'h00000040);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      k = i % 10;
      g = (i % 4 == 3) ? GRP_THREE : GRP_GEN;
      req_group <= g;
      p = (k == 7 || k == 8) ? {18'h4, seed[5:0]} : seed[23:0];
      d = (k == 7 || k == 8) ? {2'h0, seed[29:24]} : seed[31:24];
      e = g != GRP_GEN && d > 8'h01;
      s = (k % 2 == 0) ? p - d : p + d;
      if (k == 7 && s >= 24'h000140) s = s - 24'h000040;
      if (k == 8 && s < 24'h000100) s = s + 24'h000040;
      if (k == 9) s = brev_add(p, q);
      wr({2'h1, i[2:0]}, {8'h0, p});
      req(MODE_INDIR, {17'h0, k[3:0], i[2:0], d});
      `CHK(ans_addr, (k >= 1 && k <= 4) ? s : p)
      `CHK(ans_illegal, e)
      rd({2'h1, i[2:0]});
      `CHK(rv, {8'h0, (k >= 3 && !e) ? s : p})
    end
    // register and short immediate operands in every group
    for (int i = 0; i < 64; i++) begin
      seed = lfsr(seed);
      g = seed[31] ? GRP_PAR : {1'b0, seed[30]};
      req_group <= g;
      req_fp <= seed[29];
      req_imm_kind <= seed[28] ? IMM_SIGNED : {seed[27], ~seed[27]};
      sl = seed[19] ? SLOT_ANY : {seed[18], ~seed[18]};
      e = (seed[29] || g == GRP_PAR) && seed[4:0] > 5'h07 ||
        seed[4:0] > 5'h1b || g == GRP_PAR && (sl == SLOT_PAIR01 &&
        seed[4:0] > 5'h01 || sl == SLOT_PAIR23 && seed[4:1] != 4'h1);
      req(MODE_REG, {seed[31:20], sl, seed[17:0]});
      `CHK(ans_illegal, e)
      `CHK(ans_reg, seed[4:0])
      req(MODE_SIMM, seed);
      rv = seed[28] ? {{16{seed[15]}}, seed[15:0]} : {16'h0, seed[15:0]};
      `CHK(ans_imm, rv)
      `CHK(ans_illegal, g != GRP_GEN)
    end
    give_verdict();
  end
endmodule
